/* File: rtl/pmtc_map.svh */
// register map, field positions, reset values and timing figures
`ifndef PMTC_MAP_SVH
`define PMTC_MAP_SVH
`define PMTC_ADDR_INT_CFG     8'h02
`define PMTC_ADDR_PU_HI       8'h10
`define PMTC_ADDR_PU_LO       8'h11
`define PMTC_ADDR_PL_HI       8'h12
`define PMTC_ADDR_PL_LO       8'h13
`define PMTC_ADDR_FILT        8'h14
`define PMTC_ADDR_PCFG        8'h15
`define PMTC_ADDR_PINTV       8'h16
`define PMTC_ADDR_PCTL        8'h17
`define PMTC_ADDR_LU_HI       8'h20
`define PMTC_ADDR_LU_LO       8'h21
`define PMTC_ADDR_LL_HI       8'h22
`define PMTC_ADDR_LL_LO       8'h23
`define PMTC_ADDR_LCFG        8'h25
`define PMTC_ADDR_STATUS      8'h40
`define PMTC_ADDR_PRES_HI     8'h41
`define PMTC_ADDR_PRES_LO     8'h42
`define PMTC_ADDR_LRES_HI     8'h43
`define PMTC_ADDR_LRES_LO     8'h44
`define PMTC_RST_UPPER        8'hff
`define PMTC_RST_LOWER        8'h00
`define PMTC_RST_FILT         8'h11
`define PMTC_RST_INTEG        2'h1
`define PMTC_RST_INTV         8'h0a
`define PMTC_RST_AUTO_CLEAR   1'b1
`define PMTC_BIT_HYST_EN      5
`define PMTC_BIT_HYST_TRIG    4
`define PMTC_BIT_AUTO_CLEAR   1
`define PMTC_BIT_POLARITY     0
`define PMTC_BIT_REPEAT       1
`define PMTC_BIT_SHOT         0
`define PMTC_CLK_NS           40
`define PMTC_PULSE_NS         1500
`define PMTC_INTEG_BASE_NS    150000
`define PMTC_INTERVAL_UNIT_MS 5
`define PMTC_NS_PER_MS        1000000
`define PMTC_DEV_ADDR         7'h2a
`endif

/* File: rtl/pmtc_pkg.sv */
// types shared by the proximity threshold controller
package pmtc_pkg;
	typedef enum logic [3:0] {
		PMTC_IDLE  = 4'b0001,
		PMTC_INTEG = 4'b0010,
		PMTC_CONV  = 4'b0100,
		PMTC_WAIT  = 4'b1000
	} pmtc_mstate_t;

	typedef enum logic [8:0] {
		PMTC_I_IDLE  = 9'b0_0000_0001,
		PMTC_I_ADDR  = 9'b0_0000_0010,
		PMTC_I_AACK  = 9'b0_0000_0100,
		PMTC_I_REG   = 9'b0_0000_1000,
		PMTC_I_RACK  = 9'b0_0001_0000,
		PMTC_I_WDAT  = 9'b0_0010_0000,
		PMTC_I_WACK  = 9'b0_0100_0000,
		PMTC_I_RDAT  = 9'b0_1000_0000,
		PMTC_I_MACK  = 9'b1_0000_0000
	} pmtc_istate_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pmtc_regreq_t;

	typedef struct packed {
		logic [2:0]   scl_sync;
		logic [2:0]   sda_sync;
		pmtc_istate_t st;
		logic [3:0]   cnt;
		logic [7:0]   sh;
		logic [7:0]   ptr;
		logic         rnw;
		logic         nack;
		logic         drive;
		pmtc_regreq_t req;
	} pmtc_i2c_state_t;
endpackage : pmtc_pkg

/* File: rtl/pmtc_i2c_slave.sv */
// serial register port: byte-wide register access behind an open-drain data pin
`timescale 1ns/1ns
`include "pmtc_map.svh"
module pmtc_i2c_slave
	import pmtc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = `PMTC_DEV_ADDR // arbitrary value
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// bus pins
	input  wire logic         scl_in,
	input  wire logic         sda_in,
	output logic              sda_drive,
	// register side
	input  wire logic [7:0]   rdata,
	output pmtc_regreq_t      req
);
	pmtc_i2c_state_t s_ff;
	pmtc_i2c_state_t nxt_s;
	logic            scl_rise;
	logic            scl_fall;
	logic            start_c;
	logic            stop_c;

	assign sda_drive = s_ff.drive;
	assign req       = s_ff.req;

	always_comb begin
		// only the second and third stages are looked at
		scl_rise = s_ff.scl_sync[1] & ~s_ff.scl_sync[2];
		scl_fall = ~s_ff.scl_sync[1] & s_ff.scl_sync[2];
		start_c  = s_ff.scl_sync[2] & s_ff.scl_sync[1] & ~s_ff.sda_sync[1] & s_ff.sda_sync[2];
		stop_c   = s_ff.scl_sync[2] & s_ff.scl_sync[1] & s_ff.sda_sync[1] & ~s_ff.sda_sync[2];
		nxt_s = s_ff;
		nxt_s.scl_sync = {s_ff.scl_sync[1:0], scl_in};
		nxt_s.sda_sync = {s_ff.sda_sync[1:0], sda_in};
		nxt_s.req.wr = 1'b0;
		nxt_s.req.rd = 1'b0;
		// address trails the pointer so the read mux is settled at the shift-out edge
		nxt_s.req.addr = s_ff.ptr;
		if (start_c) begin
			nxt_s.st    = PMTC_I_ADDR;
			nxt_s.cnt   = 4'h0;
			nxt_s.drive = 1'b0;
		end else if (stop_c) begin
			nxt_s.st    = PMTC_I_IDLE;
			nxt_s.drive = 1'b0;
		end else if (scl_rise) begin
			if (s_ff.st == PMTC_I_MACK) begin
				nxt_s.nack = s_ff.sda_sync[2];
			end else if (s_ff.st != PMTC_I_RDAT && s_ff.cnt != 4'h8) begin
				nxt_s.sh  = {s_ff.sh[6:0], s_ff.sda_sync[2]};
				nxt_s.cnt = s_ff.cnt + 4'h1;
			end
		end else if (scl_fall) begin
			case (s_ff.st)
				PMTC_I_ADDR: begin
					if (s_ff.cnt == 4'h8) begin
						nxt_s.cnt = 4'h0;
						if (s_ff.sh[7:1] == DEV_ADDR) begin
							nxt_s.rnw   = s_ff.sh[0];
							nxt_s.drive = 1'b1;
							nxt_s.st    = PMTC_I_AACK;
						end else begin
							nxt_s.st = PMTC_I_IDLE;
						end
					end
				end
				PMTC_I_REG, PMTC_I_WDAT: begin
					if (s_ff.cnt == 4'h8) begin
						nxt_s.cnt   = 4'h0;
						nxt_s.drive = 1'b1;
						if (s_ff.st == PMTC_I_REG) begin
							nxt_s.ptr = s_ff.sh;
							nxt_s.st  = PMTC_I_RACK;
						end else begin
							nxt_s.req.wr    = 1'b1;
							nxt_s.req.addr  = s_ff.ptr;
							nxt_s.req.wdata = s_ff.sh;
							nxt_s.st        = PMTC_I_WACK;
						end
					end
				end
				PMTC_I_RACK: begin
					// the acknowledge clock was counted as a data bit, drop it
					nxt_s.cnt   = 4'h0;
					nxt_s.drive = 1'b0;
					nxt_s.st    = PMTC_I_WDAT;
				end
				PMTC_I_WACK: begin
					nxt_s.cnt   = 4'h0;
					nxt_s.drive = 1'b0;
					nxt_s.ptr   = s_ff.ptr + 8'h01;
					nxt_s.st    = PMTC_I_WDAT;
				end
				PMTC_I_AACK, PMTC_I_MACK: begin
					if (s_ff.st == PMTC_I_AACK && !s_ff.rnw) begin
						nxt_s.drive = 1'b0;
						nxt_s.cnt   = 4'h0;
						nxt_s.st    = PMTC_I_REG;
					end else if (s_ff.st == PMTC_I_MACK && s_ff.nack) begin
						nxt_s.drive = 1'b0;
						nxt_s.st    = PMTC_I_IDLE;
					end else begin
						// byte is taken from the register file at the moment it goes out
						nxt_s.sh       = rdata;
						nxt_s.drive    = ~rdata[7];
						nxt_s.req.rd   = 1'b1;
						nxt_s.req.addr = s_ff.ptr;
						nxt_s.ptr      = s_ff.ptr + 8'h01;
						nxt_s.cnt      = 4'h1;
						nxt_s.st       = PMTC_I_RDAT;
					end
				end
				PMTC_I_RDAT: begin
					if (s_ff.cnt == 4'h8) begin
						nxt_s.drive = 1'b0;
						nxt_s.st    = PMTC_I_MACK;
					end else begin
						nxt_s.sh    = {s_ff.sh[6:0], 1'b0};
						nxt_s.drive = ~s_ff.sh[6];
						nxt_s.cnt   = s_ff.cnt + 4'h1;
					end
				end
				default: begin
					nxt_s.drive = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_ff <= '{scl_sync: 3'h7, sda_sync: 3'h7, st: PMTC_I_IDLE, cnt: 4'h0, sh: 8'h00,
				ptr: 8'h00, rnw: 1'b0, nack: 1'b0, drive: 1'b0,
				req: '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00}};
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule : pmtc_i2c_slave

/* File: rtl/pmtc_ctrl.sv */
// proximity measurement sequencing, threshold decision and interrupt pin
`timescale 1ns/1ns
`include "pmtc_map.svh"
// Function
// - upper prox threshold bytes, high first, reset ones
// - lower prox threshold bytes, high first, reset zero
// - prox interrupt needs M of last N
// - filter N high nibble, M low, default one
// - zero M or N acts as one
// - integration counts LED pulses of 1.5 us
// - integration code selects 150..1200 us, default 300
// - config bit5 hysteresis enable, bit4 trigger select
// - light trigger high: set above, clear below
// - light trigger low: set below, clear above
// - hysteresis only with automatic pin update
// - light outside window raises interrupt per config
// - interval value times 5 ms, zero 5 ms
// - repeat bit runs measurements at interval
// - single shot bit self-clears on completion
// - sensing powered down after every measurement
// - upper light threshold bytes, reset ones
// - light results compared with both thresholds
// - prox hysteresis mirrors light behaviour
// - latched interrupt cleared by status read
// - auto mode re-evaluates pin every measurement
// - polarity bit zero low, one high
module pmtc_ctrl
	import pmtc_pkg::*;
#(
	parameter int         INTERVAL_UNIT_CYCLES =
		`PMTC_INTERVAL_UNIT_MS * (`PMTC_NS_PER_MS / `PMTC_CLK_NS),
	parameter int         FILTER_DEPTH         = 15,
	parameter logic [6:0] DEV_ADDR             = `PMTC_DEV_ADDR // arbitrary value
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// serial register pins, open drain data
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	// interrupt pin
	output logic             int_pin,
	// proximity front end
	output logic             led_pulse,
	output logic             prox_sense_power,
	input  wire logic        prox_result_valid,
	input  wire logic [15:0] prox_result,
	// light channel results
	input  wire logic        light_result_valid,
	input  wire logic [15:0] light_result
);
	localparam logic [10:0] CLK_NS      = 11'(`PMTC_CLK_NS);
	localparam logic [10:0] PULSE_NS    = 11'(`PMTC_PULSE_NS);
	localparam logic [10:0] BASE_PULSES = 11'(`PMTC_INTEG_BASE_NS / `PMTC_PULSE_NS);
	localparam logic [23:0] UNIT_LAST   = 24'(INTERVAL_UNIT_CYCLES - 1);

	typedef struct packed {
		logic [7:0]              pu_hi;
		logic [7:0]              pu_lo;
		logic [7:0]              pl_hi;
		logic [7:0]              pl_lo;
		logic [7:0]              filt;
		logic                    p_hyst;
		logic                    p_trig;
		logic [1:0]              p_integ;
		logic [7:0]              intv;
		logic                    repeat_run;
		logic                    single_shot;
		logic [7:0]              lu_hi;
		logic [7:0]              lu_lo;
		logic [7:0]              ll_hi;
		logic [7:0]              ll_lo;
		logic                    l_hyst;
		logic                    l_trig;
		logic                    auto_clear;
		logic                    polarity;
		logic [3:0]              flags;
		logic [15:0]             p_res;
		logic [15:0]             l_res;
		logic [FILTER_DEPTH-1:0] hist;
		pmtc_mstate_t            mst;
		logic [10:0]             acc;
		logic [10:0]             pulses;
		logic [23:0]             unit_cnt;
		logic [7:0]              wait_cnt;
		logic                    led_pulse;
		logic                    sense_power;
		logic                    int_pin;
	} pmtc_ctrl_state_t;

	pmtc_ctrl_state_t s_ff;
	pmtc_ctrl_state_t nxt_s;
	pmtc_regreq_t     req;
	logic             drive;
	logic [7:0]       rdata;
	logic             sda_oe_n_ff;
	logic             sda_out_ff;
	logic             int_active;
	logic             status_rd;
	logic [1:0]       p_flags;
	logic [1:0]       l_flags;
	logic [FILTER_DEPTH-1:0] hist_new;
	logic             p_out;

	// one flag pair for a channel; cur must already hold any read clear
	function automatic logic [1:0] pmtc_eval(input logic [15:0] res, input logic [15:0] up,
		input logic [15:0] lo, input logic hyst, input logic trig, input logic autoc,
		input logic pass, input logic [1:0] cur);
		logic       above;
		logic       below;
		logic [1:0] r;
		above = res > up;
		below = res < lo;
		r = cur;
		if (!autoc) begin
			r = cur | {above & pass, below & pass};
		end else if (!hyst) begin
			r = {above & pass, below & pass};
		end else if (trig) begin
			r[0] = 1'b0;
			if (above & pass) begin
				r[1] = 1'b1;
			end else if (below) begin
				r[1] = 1'b0;
			end
		end else begin
			r[1] = 1'b0;
			if (below & pass) begin
				r[0] = 1'b1;
			end else if (above) begin
				r[0] = 1'b0;
			end
		end
		return r;
	endfunction : pmtc_eval

	// at least M of the newest N history bits set
	function automatic logic pmtc_filter_pass(input logic [FILTER_DEPTH-1:0] h,
		input logic [3:0] n_raw, input logic [3:0] m_raw);
		logic [3:0] n;
		logic [3:0] m;
		logic [4:0] hits;
		n = (n_raw == 4'h0) ? 4'h1 : n_raw;
		m = (m_raw == 4'h0) ? 4'h1 : m_raw;
		hits = 5'h00;
		for (int i = 0; i < FILTER_DEPTH; i++) begin
			if (i < int'(n) && h[i]) begin
				hits = hits + 5'h01;
			end
		end
		return hits >= {1'b0, m};
	endfunction : pmtc_filter_pass

	pmtc_i2c_slave #(
		.DEV_ADDR (DEV_ADDR)
	) i_pmtc_i2c_slave (
		.clk       (clk),
		.srst      (srst),
		.scl_in    (scl_in),
		.sda_in    (sda_in),
		.sda_drive (drive),
		.rdata     (rdata),
		.req       (req)
	);

	assign int_pin          = s_ff.int_pin;
	assign led_pulse        = s_ff.led_pulse;
	assign prox_sense_power = s_ff.sense_power;
	assign sda_oe_n         = sda_oe_n_ff;
	assign sda_out          = sda_out_ff;
	assign int_active       = |s_ff.flags;

	always_comb begin
		rdata = 8'h00;
		if (req.addr == `PMTC_ADDR_INT_CFG) begin
			rdata = {6'h00, s_ff.auto_clear, s_ff.polarity};
		end else if (req.addr == `PMTC_ADDR_PU_HI) begin
			rdata = s_ff.pu_hi;
		end else if (req.addr == `PMTC_ADDR_PU_LO) begin
			rdata = s_ff.pu_lo;
		end else if (req.addr == `PMTC_ADDR_PL_HI) begin
			rdata = s_ff.pl_hi;
		end else if (req.addr == `PMTC_ADDR_PL_LO) begin
			rdata = s_ff.pl_lo;
		end else if (req.addr == `PMTC_ADDR_FILT) begin
			rdata = s_ff.filt;
		end else if (req.addr == `PMTC_ADDR_PCFG) begin
			rdata = {2'h0, s_ff.p_hyst, s_ff.p_trig, 2'h0, s_ff.p_integ};
		end else if (req.addr == `PMTC_ADDR_PINTV) begin
			rdata = s_ff.intv;
		end else if (req.addr == `PMTC_ADDR_PCTL) begin
			rdata = {6'h00, s_ff.repeat_run, s_ff.single_shot};
		end else if (req.addr == `PMTC_ADDR_LU_HI) begin
			rdata = s_ff.lu_hi;
		end else if (req.addr == `PMTC_ADDR_LU_LO) begin
			rdata = s_ff.lu_lo;
		end else if (req.addr == `PMTC_ADDR_LL_HI) begin
			rdata = s_ff.ll_hi;
		end else if (req.addr == `PMTC_ADDR_LL_LO) begin
			rdata = s_ff.ll_lo;
		end else if (req.addr == `PMTC_ADDR_LCFG) begin
			rdata = {2'h0, s_ff.l_hyst, s_ff.l_trig, 4'h0};
		end else if (req.addr == `PMTC_ADDR_STATUS) begin
			rdata = {3'h0, int_active, s_ff.flags};
		end else if (req.addr == `PMTC_ADDR_PRES_HI) begin
			rdata = s_ff.p_res[15:8];
		end else if (req.addr == `PMTC_ADDR_PRES_LO) begin
			rdata = s_ff.p_res[7:0];
		end else if (req.addr == `PMTC_ADDR_LRES_HI) begin
			rdata = s_ff.l_res[15:8];
		end else if (req.addr == `PMTC_ADDR_LRES_LO) begin
			rdata = s_ff.l_res[7:0];
		end
	end

	always_comb begin
		nxt_s = s_ff;
		nxt_s.led_pulse = 1'b0;
		status_rd = req.rd && (req.addr == `PMTC_ADDR_STATUS) && !s_ff.auto_clear;
		if (status_rd) begin
			nxt_s.flags = 4'h0;
		end
		p_out    = (prox_result > {s_ff.pu_hi, s_ff.pu_lo}) ||
			(prox_result < {s_ff.pl_hi, s_ff.pl_lo});
		hist_new = {s_ff.hist[FILTER_DEPTH-2:0], p_out};
		p_flags  = pmtc_eval(prox_result, {s_ff.pu_hi, s_ff.pu_lo}, {s_ff.pl_hi, s_ff.pl_lo},
			s_ff.p_hyst, s_ff.p_trig, s_ff.auto_clear,
			pmtc_filter_pass(hist_new, s_ff.filt[7:4], s_ff.filt[3:0]), nxt_s.flags[1:0]);
		l_flags  = pmtc_eval(light_result, {s_ff.lu_hi, s_ff.lu_lo}, {s_ff.ll_hi, s_ff.ll_lo},
			s_ff.l_hyst, s_ff.l_trig, s_ff.auto_clear, 1'b1, nxt_s.flags[3:2]);
		if (req.wr) begin
			if (req.addr == `PMTC_ADDR_INT_CFG) begin
				nxt_s.auto_clear = req.wdata[`PMTC_BIT_AUTO_CLEAR];
				nxt_s.polarity   = req.wdata[`PMTC_BIT_POLARITY];
			end else if (req.addr == `PMTC_ADDR_PU_HI) begin
				nxt_s.pu_hi = req.wdata;
			end else if (req.addr == `PMTC_ADDR_PU_LO) begin
				nxt_s.pu_lo = req.wdata;
			end else if (req.addr == `PMTC_ADDR_PL_HI) begin
				nxt_s.pl_hi = req.wdata;
			end else if (req.addr == `PMTC_ADDR_PL_LO) begin
				nxt_s.pl_lo = req.wdata;
			end else if (req.addr == `PMTC_ADDR_FILT) begin
				nxt_s.filt = req.wdata;
			end else if (req.addr == `PMTC_ADDR_PCFG) begin
				nxt_s.p_hyst  = req.wdata[`PMTC_BIT_HYST_EN];
				nxt_s.p_trig  = req.wdata[`PMTC_BIT_HYST_TRIG];
				nxt_s.p_integ = req.wdata[1:0];
			end else if (req.addr == `PMTC_ADDR_PINTV) begin
				nxt_s.intv = req.wdata;
			end else if (req.addr == `PMTC_ADDR_PCTL) begin
				nxt_s.repeat_run  = req.wdata[`PMTC_BIT_REPEAT];
				nxt_s.single_shot = req.wdata[`PMTC_BIT_SHOT] | s_ff.single_shot;
			end else if (req.addr == `PMTC_ADDR_LU_HI) begin
				nxt_s.lu_hi = req.wdata;
			end else if (req.addr == `PMTC_ADDR_LU_LO) begin
				nxt_s.lu_lo = req.wdata;
			end else if (req.addr == `PMTC_ADDR_LL_HI) begin
				nxt_s.ll_hi = req.wdata;
			end else if (req.addr == `PMTC_ADDR_LL_LO) begin
				nxt_s.ll_lo = req.wdata;
			end else if (req.addr == `PMTC_ADDR_LCFG) begin
				nxt_s.l_hyst = req.wdata[`PMTC_BIT_HYST_EN];
				nxt_s.l_trig = req.wdata[`PMTC_BIT_HYST_TRIG];
			end
		end
		if (light_result_valid) begin
			nxt_s.l_res       = light_result;
			nxt_s.flags[3:2]  = l_flags;
		end
		case (s_ff.mst)
			PMTC_IDLE: begin
				if (s_ff.single_shot || s_ff.repeat_run) begin
					nxt_s.mst         = PMTC_INTEG;
					nxt_s.sense_power = 1'b1;
					nxt_s.acc         = 11'h000;
					nxt_s.pulses      = BASE_PULSES << s_ff.p_integ;
				end
			end
			PMTC_INTEG: begin
				// fractional accumulator keeps the mean pulse period exact off a 40 ns clock
				if (s_ff.acc + CLK_NS >= PULSE_NS) begin
					nxt_s.acc       = s_ff.acc + CLK_NS - PULSE_NS;
					nxt_s.led_pulse = 1'b1;
					nxt_s.pulses    = s_ff.pulses - 11'h001;
					if (s_ff.pulses == 11'h001) begin
						nxt_s.mst = PMTC_CONV;
					end
				end else begin
					nxt_s.acc = s_ff.acc + CLK_NS;
				end
			end
			PMTC_CONV: begin
				if (prox_result_valid) begin
					nxt_s.p_res       = prox_result;
					nxt_s.hist        = hist_new;
					nxt_s.flags[1:0]  = p_flags;
					nxt_s.sense_power = 1'b0;
					nxt_s.single_shot = 1'b0;
					nxt_s.unit_cnt    = 24'h00_0000;
					nxt_s.wait_cnt    = (s_ff.intv == 8'h00) ? 8'h01 : s_ff.intv;
					nxt_s.mst         = s_ff.repeat_run ? PMTC_WAIT : PMTC_IDLE;
				end
			end
			PMTC_WAIT: begin
				if (!s_ff.repeat_run) begin
					nxt_s.mst = PMTC_IDLE;
				end else if (s_ff.unit_cnt == UNIT_LAST) begin
					nxt_s.unit_cnt = 24'h00_0000;
					nxt_s.wait_cnt = s_ff.wait_cnt - 8'h01;
					if (s_ff.wait_cnt == 8'h01) begin
						nxt_s.mst = PMTC_IDLE;
					end
				end else begin
					nxt_s.unit_cnt = s_ff.unit_cnt + 24'h00_0001;
				end
			end
			default: begin
				nxt_s.mst = PMTC_IDLE;
			end
		endcase
		nxt_s.int_pin = s_ff.polarity ? int_active : ~int_active;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_ff <= '{pu_hi: `PMTC_RST_UPPER, pu_lo: `PMTC_RST_UPPER,
				pl_hi: `PMTC_RST_LOWER, pl_lo: `PMTC_RST_LOWER,
				filt: `PMTC_RST_FILT, p_hyst: 1'b0, p_trig: 1'b0, p_integ: `PMTC_RST_INTEG,
				intv: `PMTC_RST_INTV, repeat_run: 1'b0, single_shot: 1'b0,
				lu_hi: `PMTC_RST_UPPER, lu_lo: `PMTC_RST_UPPER,
				ll_hi: `PMTC_RST_LOWER, ll_lo: `PMTC_RST_LOWER, l_hyst: 1'b0, l_trig: 1'b0,
				auto_clear: `PMTC_RST_AUTO_CLEAR, polarity: 1'b0, flags: 4'h0,
				p_res: 16'h0000, l_res: 16'h0000, hist: '0, mst: PMTC_IDLE,
				acc: 11'h000, pulses: 11'h000, unit_cnt: 24'h00_0000, wait_cnt: 8'h00,
				led_pulse: 1'b0, sense_power: 1'b0, int_pin: 1'b1};
			sda_oe_n_ff <= 1'b1;
			sda_out_ff  <= 1'b0;
		end else begin
			s_ff        <= nxt_s;
			sda_oe_n_ff <= ~drive;
			sda_out_ff  <= 1'b0;
		end
	end
endmodule : pmtc_ctrl

/* File: sim/pmtc_ctrl_sva.sv */
// pin-level checks on the proximity controller
`timescale 1ns/1ns
module pmtc_ctrl_sva (
	// clock and reset
	input wire logic        clk,
	input wire logic        srst,
	// serial and interrupt pins
	input wire logic        scl_in,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe_n,
	input wire logic        int_pin,
	// front end
	input wire logic        led_pulse,
	input wire logic        prox_sense_power,
	input wire logic        prox_result_valid,
	input wire logic [15:0] prox_result,
	input wire logic        light_result_valid,
	input wire logic [15:0] light_result
);
	logic [9:0] pulse_cnt_ff;
	logic [9:0] nxt_pulse_cnt;
	// counts the pulses of the current measurement only
	always_comb begin
		nxt_pulse_cnt = prox_sense_power ? pulse_cnt_ff + 10'(led_pulse) : '0;
	end
	always_ff @(posedge clk) begin
		pulse_cnt_ff <= srst ? '0 : nxt_pulse_cnt;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_power_off;
		$fell(prox_sense_power);
	endsequence
	sequence s_quiet;
		!led_pulse [*8];
	endsequence
	property p_pulse_gap;
		led_pulse |=> s_quiet;
	endproperty
	property p_led_powered;
		led_pulse |-> prox_sense_power;
	endproperty
	property p_first_pulse;
		$rose(prox_sense_power) |-> ##[0:45] led_pulse;
	endproperty
	property p_pulse_count;
		s_power_off |-> pulse_cnt_ff inside {10'h064, 10'h0c8, 10'h190, 10'h320};
	endproperty
	property p_off_after_result;
		s_power_off |-> $past(prox_result_valid) || $past(prox_result_valid, 2);
	endproperty
	property p_idle_level;
		$fell(srst) |-> int_pin;
	endproperty
	property p_open_drain;
		sda_out == 1'b0;
	endproperty
	property p_drive_in_low;
		$changed(sda_oe_n) |-> !scl_in;
	endproperty
	a_pulse_gap: assert property (p_pulse_gap) else $error("pulse gap");
	a_led_powered: assert property (p_led_powered) else $error("pulse unpowered");
	a_first_pulse: assert property (p_first_pulse) else $error("no pulse");
	a_pulse_count: assert property (p_pulse_count) else $error("pulse count");
	a_off_after_result: assert property (p_off_after_result) else $error("power off");
	a_idle_level: assert property (p_idle_level) else $error("pin level");
	a_open_drain: assert property (p_open_drain) else $error("data drives high");
	a_drive_in_low: assert property (p_drive_in_low) else $error("data moved");
endmodule : pmtc_ctrl_sva

/* File: sim/pmtc_host_model.sv */
// serial bus host: clock line and open-drain data line with pull-up
`timescale 1ns/1ns
`include "pmtc_map.svh"
module pmtc_host_model (
	// clock
	input wire logic   clk,
	// bus lines
	input wire logic   sda_oe_n,
	output logic       scl,
	output logic       sda,
	// read results
	output logic       rd_stb,
	output logic [7:0] rd_dat
);
	logic drv_ff = 1'b1;
	initial begin
		scl = 1'b1;
		rd_stb = 1'b0;
		rd_dat = '0;
	end
	// enable still unknown before reset counts as released
	assign sda = drv_ff & (sda_oe_n !== 1'b0);
	task automatic hp;
		repeat (10) @(posedge clk);
	endtask : hp
	task automatic bit_io(input logic b, output logic q);
		@(posedge clk) drv_ff <= b;
		hp;
		scl <= 1'b1;
		hp;
		q = sda;
		scl <= 1'b0;
	endtask : bit_io
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q);
		logic k;
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(last, k);
	endtask : xfer
	task automatic start;
		@(posedge clk) drv_ff <= 1'b1;
		hp;
		scl <= 1'b1;
		hp;
		drv_ff <= 1'b0;
		hp;
		scl <= 1'b0;
	endtask : start
	task automatic stop;
		@(posedge clk) drv_ff <= 1'b0;
		hp;
		scl <= 1'b1;
		hp;
		drv_ff <= 1'b1;
		hp;
	endtask : stop
	task automatic head(input logic [7:0] a);
		logic [7:0] q;
		start;
		xfer({`PMTC_DEV_ADDR, 1'b0}, 1'b1, q);
		xfer(a, 1'b1, q);
	endtask : head
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] q;
		head(a);
		xfer(v, 1'b1, q);
		stop;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic [7:0] q;
		head(a);
		start;
		xfer({`PMTC_DEV_ADDR, 1'b1}, 1'b1, q);
		xfer(8'hff, 1'b1, q);
		rd_dat <= q;
		rd_stb <= 1'b1;
		@(posedge clk) rd_stb <= 1'b0;
		stop;
	endtask : rd
endmodule : pmtc_host_model

/* File: sim/tb_pmtc_ctrl.sv */
// self-checking bench for the proximity threshold controller
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
	$display("Error %0t: got %h want %h", $time, a, b); end end
module tb_pmtc_ctrl;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        scl, sda, sda_out, sda_oe_n, int_pin, led_pulse, prox_sense_power;
	logic        prox_result_valid = 1'b0;
	logic [15:0] prox_result = '0;
	logic        light_result_valid = 1'b0;
	logic [15:0] light_result = '0;
	logic        rd_stb;
	logic [7:0]  rd_dat, e_mon;
	logic [7:0]  exp_q[$];
	logic [15:0] res_q[$];
	logic [15:0] r;
	int          err_total = 0;
	int          check_count = 0;
	int          npul = 0, dly = 0, done_cnt = 0, code = 0, k;
	logic [7:0]  ra[11] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h20, 8'h21, 8'h30};
	logic [7:0]  rv[11] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h11, 8'h01, 8'h0a, 8'h00, 8'hff, 8'hff, 8'h00};
	logic [7:0]  ta[8] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h20, 8'h21, 8'h22, 8'h23};
	logic [7:0]  tv[8] = '{8'h80, 8'h00, 8'h10, 8'h00, 8'h80, 8'h00, 8'h10, 8'h00};
	logic [15:0] lv[6] = '{16'h9000, 16'h4000, 16'h0800, 16'h0800, 16'h4000, 16'h9000};
	logic [7:0]  le[6] = '{8'h18, 8'h18, 8'h00, 8'h14, 8'h14, 8'h00};
	always #20 clk = ~clk;
	pmtc_ctrl #(.INTERVAL_UNIT_CYCLES(20)) i_pmtc_ctrl (.clk(clk), .srst(srst), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_pin(int_pin),
		.led_pulse(led_pulse), .prox_sense_power(prox_sense_power),
		.prox_result_valid(prox_result_valid), .prox_result(prox_result),
		.light_result_valid(light_result_valid), .light_result(light_result));
	pmtc_host_model i_pmtc_host_model (.clk(clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda),
		.rd_stb(rd_stb), .rd_dat(rd_dat));
	// front end answers only after the full pulse train
	always @(posedge clk) begin
		prox_result_valid <= 1'b0;
		if (dly == 1) begin
			prox_result_valid <= 1'b1;
			prox_result <= (res_q.size() > 0) ? res_q.pop_front() : 16'h4000;
			done_cnt++;
		end
		if (dly > 0) dly--;
		if (!prox_sense_power) npul = 0;
		if (led_pulse) npul++;
		if (led_pulse && npul == (100 << code)) dly = 6;
	end
	always @(posedge clk) begin
		if (rd_stb) begin
			e_mon = exp_q.pop_front();
			`CHK(rd_dat, e_mon)
		end
	end
	function automatic logic [7:0] st(input logic hi, input logic lo);
		return {3'h0, hi | lo, 2'h0, hi, lo};
	endfunction : st
	task automatic finish_test;
		if (err_total == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_pmtc_host_model.rd(a);
	endtask : rchk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		i_pmtc_host_model.wr(a, v);
	endtask : wr
	task automatic wait_valid;
		int n;
		n = done_cnt;
		for (int i = 0; i < 40000 && done_cnt == n; i++) @(posedge clk);
	endtask : wait_valid
	task automatic shot(input logic [15:0] v, input logic [7:0] e);
		res_q.push_back(v);
		wr(8'h17, 8'h01);
		wait_valid;
		repeat (4) @(posedge clk);
		`CHK(int_pin, ~e[4])
		rchk(8'h40, e);
	endtask : shot
	task automatic light(input logic [15:0] v);
		@(posedge clk);
		light_result <= v;
		light_result_valid <= 1'b1;
		@(posedge clk);
		light_result_valid <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : light
	task automatic gap(input int e);
		wait_valid;
		while (prox_sense_power) @(posedge clk);
		k = 0;
		while (!prox_sense_power && k < 2000) begin
			@(posedge clk);
			k++;
		end
		`CHK(k >= e - 1 && k <= e + 5, 1'b1)
	endtask : gap
	initial begin
		#6000000;
		err_total++;
		finish_test;
	end
	initial begin
		void'($urandom(32'h4426));
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		foreach (ra[i]) rchk(ra[i], rv[i]);
		for (int i = 0; i < 4; i++) begin
			r = 16'($urandom);
			wr(8'h10 + 8'(i), r[7:0]);
			rchk(8'h10 + 8'(i), r[7:0]);
		end
		foreach (ta[i]) wr(ta[i], tv[i]);
		for (int c = 0; c < 2; c++) begin
			code = c;
			wr(8'h15, 8'(c));
			r = 16'($urandom);
			shot(r, st(r > 16'h8000, r < 16'h1000));
		end
		rchk(8'h17, 8'h00);
		code = 0;
		wr(8'h15, 8'h00);
		wr(8'h14, 8'h00);
		shot(16'h0100, st(1'b0, 1'b1));
		wr(8'h14, 8'h22);
		shot(16'h4000, 8'h00);
		shot(16'hf000, 8'h00);
		shot(16'hf000, st(1'b1, 1'b0));
		wr(8'h14, 8'h11);
		wr(8'h15, 8'h30);
		shot(16'h9000, st(1'b1, 1'b0));
		shot(16'h4000, st(1'b1, 1'b0));
		shot(16'h0800, 8'h00);
		wr(8'h15, 8'h00);
		for (int i = 0; i < 6; i++) begin
			if (i % 3 == 0) wr(8'h25, (i == 0) ? 8'h30 : 8'h20);
			light(lv[i]);
			rchk(8'h40, le[i]);
		end
		wr(8'h02, 8'h00);
		light(16'h9000);
		light(16'h4000);
		`CHK(int_pin, 1'b0)
		rchk(8'h40, 8'h18);
		rchk(8'h40, 8'h00);
		`CHK(int_pin, 1'b1)
		light(16'h9000);
		wr(8'h02, 8'h01);
		`CHK(int_pin, 1'b1)
		rchk(8'h40, 8'h18);
		`CHK(int_pin, 1'b0)
		wr(8'h02, 8'h02);
		wr(8'h16, 8'h00);
		wr(8'h17, 8'h02);
		gap(20);
		wr(8'h16, 8'h03);
		gap(60);
		wr(8'h17, 8'h00);
		repeat (4000) @(posedge clk);
		k = 0;
		repeat (300) begin
			@(posedge clk);
			k += int'(prox_sense_power !== 1'b0);
		end
		`CHK(k, 0)
		finish_test;
	end
endmodule : tb_pmtc_ctrl
bind pmtc_ctrl pmtc_ctrl_sva i_pmtc_ctrl_sva (.clk(clk), .srst(srst), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_pin(int_pin),
	.led_pulse(led_pulse), .prox_sense_power(prox_sense_power),
	.prox_result_valid(prox_result_valid), .prox_result(prox_result),
	.light_result_valid(light_result_valid), .light_result(light_result));
